// >>> design/vfd_pkg.sv
// shared constants and types for the display timing and dimming block
`default_nettype none
package vfd_pkg;
  localparam int unsigned SEG_W      = 32;
  localparam int unsigned DIM_W      = 10;
  localparam int unsigned MODE_W     = 3;
  localparam int unsigned FRAME_W    = SEG_W + MODE_W;
  // dimming field sits below the mode bits once a 13-bit frame is in
  localparam int unsigned DIM_LSB    = FRAME_W - (DIM_W + MODE_W);
  localparam logic [DIM_W-1:0] DIM_MAX = 10'h3f8;   // 1016
  localparam logic [DIM_W-1:0] DIM_RESET = 10'h000;
  localparam logic [SEG_W-1:0] SEG_RESET = 32'h0000_0000;
  // oscillator cycles per bit time, bit times per grid slot
  localparam int unsigned BIT_CYCLES = 4;
  localparam logic [1:0] BIT_LAST    = 2'(BIT_CYCLES - 1);
  localparam logic [DIM_W-1:0] SLOT_LAST = 10'h3ff;  // 1024 bit times
  // function codes written as {m2, m1, m0}
  localparam logic [2:0] FN_SEG_ALL  = 3'h0;
  localparam logic [2:0] FN_SEG_ONE  = 3'h1;
  localparam logic [2:0] FN_SEG_TWO  = 3'h2;
  localparam logic [2:0] FN_SEG_THR  = 3'h3;
  localparam logic [2:0] FN_DIMMING  = 3'h4;
  typedef enum logic [2:0]
  {
    GRID_ONE   = 3'b001,
    GRID_TWO   = 3'b010,
    GRID_THREE = 3'b100
  } grid_state_e;
endpackage
`default_nettype wire

// >>> design/frame_if.sv
// frame hand-over from the serial receiver to the display core
`timescale 1ns/100ps
`default_nettype none
interface frame_if;
  logic                           load;
  logic [vfd_pkg::MODE_W-1:0]     mode;
  logic [vfd_pkg::SEG_W-1:0]      seg_word;
  logic [vfd_pkg::DIM_W-1:0]      dim_word;
  modport rx   (output load, output mode, output seg_word, output dim_word);
  modport core (input load, input mode, input seg_word, input dim_word);
endinterface
`default_nettype wire

// >>> design/serial_frame_rx.sv
// three-wire serial receiver: samples pins, shifts bits, loads on select fall
`timescale 1ns/100ps
`default_nettype none
module serial_frame_rx
(
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic shift_clk,
  input  wire logic serial_data,
  input  wire logic chip_select,
  frame_if.rx       frame
);
  logic [2:0]                   sync1_reg;
  logic [2:0]                   sync2_reg;
  logic                         sclk_prev_reg;
  logic                         cs_prev_reg;
  logic [vfd_pkg::FRAME_W-1:0]  shift_reg;
  logic                         sclk_rise;
  logic                         cs_fall;

  // two-flop synchronisers for the pins
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
    end
    else
    begin
      sync1_reg <= {chip_select, serial_data, shift_clk};
      sync2_reg <= sync1_reg;
    end
  end

  // edge history
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sclk_prev_reg <= 1'b0;
      cs_prev_reg   <= 1'b0;
    end
    else
    begin
      sclk_prev_reg <= sync2_reg[0];
      cs_prev_reg   <= sync2_reg[2];
    end
  end

  assign sclk_rise = sync2_reg[0] & ~sclk_prev_reg;
  assign cs_fall   = cs_prev_reg & ~sync2_reg[2];

  always_ff @(posedge clk)
  begin
    if (reset)
      shift_reg <= '0;
    else if (sclk_rise && sync2_reg[2])
      shift_reg <= {sync2_reg[1], shift_reg[vfd_pkg::FRAME_W-1:1]};
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      frame.load     <= 1'b0;
      frame.mode     <= vfd_pkg::FN_SEG_ALL;
      frame.seg_word <= vfd_pkg::SEG_RESET;
      frame.dim_word <= vfd_pkg::DIM_RESET;
    end
    else
    begin
      frame.load     <= cs_fall;
      frame.mode     <= shift_reg[vfd_pkg::FRAME_W-1 -: vfd_pkg::MODE_W];
      frame.seg_word <= shift_reg[vfd_pkg::SEG_W-1:0];
      frame.dim_word <= shift_reg[vfd_pkg::DIM_LSB +: vfd_pkg::DIM_W];
    end
  end
endmodule
`default_nettype wire

// >>> design/vfd_dimming_grid_sequencer.sv
// grid sequencer, dimming and segment output stage of the display driver
`timescale 1ns/100ps
`default_nettype none
module vfd_dimming_grid_sequencer
(
  input  wire logic                       clk,
  input  wire logic                       reset,
  input  wire logic                       shift_clk,
  input  wire logic                       serial_data,
  input  wire logic                       chip_select,
  input  wire logic                       master_select,
  input  wire logic                       duty_select,
  input  wire logic                       dimming_pulse_in,
  input  wire logic                       grid_sync_in_a,
  input  wire logic                       grid_sync_in_b,
  output var  logic [vfd_pkg::SEG_W-1:0]  segment_outputs,
  output var  logic                       grid_drive_one,
  output var  logic                       grid_drive_two,
  output var  logic                       grid_drive_three,
  output var  logic                       dimming_pulse_out,
  output var  logic                       grid_sync_out_a,
  output var  logic                       grid_sync_out_b
);
  frame_if frame ();

  logic [4:0]                     pin1_reg;
  logic [4:0]                     pin2_reg;
  logic [vfd_pkg::SEG_W-1:0]      latch_reg [3];
  logic [vfd_pkg::DIM_W-1:0]      dim_reg;
  logic [1:0]                     prescale_reg;
  logic [vfd_pkg::DIM_W-1:0]      bit_cnt_reg;
  vfd_pkg::grid_state_e           grid_reg;
  vfd_pkg::grid_state_e           grid_next;
  logic                           bit_tick;
  logic [vfd_pkg::DIM_W-1:0]      duty;
  logic                           on_phase;
  logic                           is_master;
  logic [2:0]                     slave_sel;
  logic [2:0]                     wr_mask;

  // latch write mask from the function code
  function automatic logic [2:0] latch_mask(input logic [2:0] code);
    case (code)
      vfd_pkg::FN_SEG_ALL: latch_mask = 3'h7;
      vfd_pkg::FN_SEG_ONE: latch_mask = 3'h1;
      vfd_pkg::FN_SEG_TWO: latch_mask = 3'h2;
      vfd_pkg::FN_SEG_THR: latch_mask = 3'h4;
      default:             latch_mask = 3'h0;
    endcase
  endfunction

  // one-hot latch choice to segment word
  function automatic logic [vfd_pkg::SEG_W-1:0] pick_latch
  (
    input logic [2:0]                sel,
    input logic [vfd_pkg::SEG_W-1:0] l0,
    input logic [vfd_pkg::SEG_W-1:0] l1,
    input logic [vfd_pkg::SEG_W-1:0] l2
  );
    pick_latch = ({vfd_pkg::SEG_W{sel[0]}} & l0)
               | ({vfd_pkg::SEG_W{sel[1]}} & l1)
               | ({vfd_pkg::SEG_W{sel[2]}} & l2);
  endfunction

  serial_frame_rx u_rx
  (
    .clk         (clk),
    .reset       (reset),
    .shift_clk   (shift_clk),
    .serial_data (serial_data),
    .chip_select (chip_select),
    .frame       (frame.rx)
  );

  // two-flop synchronisers for mode and slave pins
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pin1_reg <= 5'h00;
      pin2_reg <= 5'h00;
    end
    else
    begin
      pin1_reg <= {master_select, duty_select, dimming_pulse_in,
                   grid_sync_in_b, grid_sync_in_a};
      pin2_reg <= pin1_reg;
    end
  end

  assign is_master = pin2_reg[4];
  assign slave_sel = {pin2_reg[0] & pin2_reg[1],
                      ~pin2_reg[0] & pin2_reg[1],
                      pin2_reg[0] & ~pin2_reg[1]};

  assign wr_mask = latch_mask(frame.mode);

  generate
    for (genvar i = 0; i < 3; i++)
    begin : g_latch
      always_ff @(posedge clk)
      begin
        if (reset)
          latch_reg[i] <= vfd_pkg::SEG_RESET;
        else if (frame.load && wr_mask[i])
          latch_reg[i] <= frame.seg_word;
      end
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (reset)
      dim_reg <= vfd_pkg::DIM_RESET;
    else if (frame.load && frame.mode == vfd_pkg::FN_DIMMING)
      dim_reg <= frame.dim_word;
  end

  assign duty = (dim_reg > vfd_pkg::DIM_MAX) ? vfd_pkg::DIM_MAX : dim_reg;

  always_ff @(posedge clk)
  begin
    if (reset)
      prescale_reg <= 2'h0;
    else
      prescale_reg <= (prescale_reg == vfd_pkg::BIT_LAST) ? 2'h0 : prescale_reg + 2'h1;
  end
  assign bit_tick = (prescale_reg == vfd_pkg::BIT_LAST);

  always_ff @(posedge clk)
  begin
    if (reset)
      bit_cnt_reg <= '0;
    else if (bit_tick)
      bit_cnt_reg <= bit_cnt_reg + 10'h001;
  end

  always_comb
  begin
    grid_next = grid_reg;
    case (grid_reg)
      vfd_pkg::GRID_ONE:   grid_next = vfd_pkg::GRID_TWO;
      vfd_pkg::GRID_TWO:   grid_next = pin2_reg[3] ? vfd_pkg::GRID_ONE : vfd_pkg::GRID_THREE;
      vfd_pkg::GRID_THREE: grid_next = vfd_pkg::GRID_ONE;
      default:             grid_next = vfd_pkg::GRID_ONE;
    endcase
  end

  // grid advance at end of slot
  always_ff @(posedge clk)
  begin
    if (reset)
      grid_reg <= vfd_pkg::GRID_ONE;
    else if (bit_tick && bit_cnt_reg == vfd_pkg::SLOT_LAST)
      grid_reg <= grid_next;
  end

  assign on_phase = (bit_cnt_reg < duty);

  always_ff @(posedge clk)
  begin
    if (reset)
      segment_outputs <= vfd_pkg::SEG_RESET;
    else if (is_master)
      segment_outputs <= on_phase ? pick_latch(grid_reg, latch_reg[0], latch_reg[1],
                                               latch_reg[2]) : vfd_pkg::SEG_RESET;
    else
      segment_outputs <= pin2_reg[2] ? pick_latch(slave_sel, latch_reg[0], latch_reg[1],
                                                  latch_reg[2]) : vfd_pkg::SEG_RESET;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      grid_drive_one    <= 1'b0;
      grid_drive_two    <= 1'b1;
      grid_drive_three  <= 1'b1;
      dimming_pulse_out <= 1'b0;
      grid_sync_out_a   <= 1'b0;
      grid_sync_out_b   <= 1'b0;
    end
    else if (is_master)
    begin
      grid_drive_one    <= ~(grid_reg[0] & on_phase);   // active low
      grid_drive_two    <= ~(grid_reg[1] & on_phase);
      grid_drive_three  <= ~(grid_reg[2] & on_phase);
      dimming_pulse_out <= on_phase;
      grid_sync_out_a   <= grid_reg[0] | grid_reg[2];
      grid_sync_out_b   <= grid_reg[1] | grid_reg[2];
    end
    else
    begin
      grid_drive_one    <= 1'b1;
      grid_drive_two    <= 1'b1;
      grid_drive_three  <= 1'b1;
      dimming_pulse_out <= 1'b0;
      grid_sync_out_a   <= 1'b0;
      grid_sync_out_b   <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> bench/serial_host_model.sv
// controller model sending frames on the three-wire port
`timescale 1ns/100ps
`default_nettype none
module serial_host_model
(
  output var logic shift_clk,
  output var logic serial_data,
  output var logic chip_select
);
  initial
  begin
    shift_clk = 1'b0;
    serial_data = 1'b0;
    chip_select = 1'b0;
  end
  task automatic send(input logic [34:0] f, input int n);
    chip_select = 1'b1;
    #201;
    for (int i = 0; i < n; i++)
    begin
      serial_data = f[i];
      #24 shift_clk = 1'b1;
      #24 shift_clk = 1'b0;
    end
    #200 chip_select = 1'b0;
    serial_data = ~serial_data; // no stale bit
    #401;
  endtask
endmodule
`default_nettype wire

// >>> bench/vfd_monitor.sv
// checker of the display stage outputs
`timescale 1ns/100ps
`default_nettype none
module vfd_monitor
(
  input wire logic                      clk,
  input wire logic                      reset,
  input wire logic                      master_select,
  input wire logic                      dimming_pulse_in,
  input wire logic                      grid_sync_in_a,
  input wire logic                      grid_sync_in_b,
  input wire logic [vfd_pkg::SEG_W-1:0] segment_outputs,
  input wire logic                      grid_drive_one,
  input wire logic                      grid_drive_two,
  input wire logic                      grid_drive_three,
  input wire logic                      dimming_pulse_out,
  input wire logic                      grid_sync_out_a,
  input wire logic                      grid_sync_out_b
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic [12:0] on_cnt_reg;
  logic        sl;
  logic        dark;
  logic        g_off;
  // helper levels
  assign sl = !master_select;
  assign dark = segment_outputs == 32'h0000_0000;
  assign g_off = grid_drive_one && grid_drive_two && grid_drive_three;
  // length of the running on-phase
  always_ff @(posedge clk)
    on_cnt_reg <= (reset || !dimming_pulse_out) ? 13'h0000 : on_cnt_reg + 13'h0001;
  property p_init; $fell(reset) |-> !grid_drive_one && grid_drive_two && grid_drive_three && dark;
  endproperty
  a_init: assert property (p_init) else $error("bad state after reset");
  property p_sl_grid; sl [*6] |-> g_off; endproperty
  a_sl_grid: assert property (p_sl_grid) else $error("slave grid low");
  property p_sl_outs; sl [*6] |-> !dimming_pulse_out && !grid_sync_out_a && !grid_sync_out_b;
  endproperty
  a_sl_outs: assert property (p_sl_outs) else $error("slave outputs high");
  property p_sl_dark; (sl && !dimming_pulse_in) [*6] |-> dark; endproperty
  a_sl_dark: assert property (p_sl_dark) else $error("slave lit while gated");
  property p_sl_none; (sl && !grid_sync_in_a && !grid_sync_in_b) [*6] |-> dark; endproperty
  a_sl_none: assert property (p_sl_none) else $error("slave lit, no latch");
  property p_m_off; master_select [*6] ##0 !dimming_pulse_out |-> dark && g_off; endproperty
  a_m_off: assert property (p_m_off) else $error("lit in off-phase");
  property p_m_grid;
    master_select [*6] |-> $countones({grid_drive_one, grid_drive_two, grid_drive_three}) > 1;
  endproperty
  a_m_grid: assert property (p_m_grid) else $error("two grids on");
  property p_m_sync;
    master_select [*6] ##0 !grid_drive_one |-> grid_sync_out_a && !grid_sync_out_b;
  endproperty
  a_m_sync: assert property (p_m_sync) else $error("bad sync code");
  property p_m_sync_two;
    master_select [*6] ##0 !grid_drive_two |-> !grid_sync_out_a && grid_sync_out_b;
  endproperty
  a_m_sync_two: assert property (p_m_sync_two) else $error("grid two sync");
  property p_m_sync_three;
    master_select [*6] ##0 !grid_drive_three |-> grid_sync_out_a && grid_sync_out_b;
  endproperty
  a_m_sync_three: assert property (p_m_sync_three) else $error("grid three sync");
  property p_clamp; on_cnt_reg <= 13'h0fe0; endproperty
  a_clamp: assert property (p_clamp) else $error("on-phase too long");
  c_clamp: cover property (on_cnt_reg == 13'h0fe0);
  c_g3: cover property (master_select && !grid_drive_three);
  c_lit: cover property (sl && !dark);
endmodule
`default_nettype wire

// >>> bench/testbench.sv
// self-checking bench for the display timing and dimming block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        master_select = 1'b0;
  logic        duty_select = 1'b0;
  logic        dimming_pulse_in = 1'b0;
  logic        grid_sync_in_a = 1'b0;
  logic        grid_sync_in_b = 1'b0;
  wire         shift_clk;
  wire         serial_data;
  wire         chip_select;
  logic [31:0] segment_outputs;
  logic        grid_drive_one;
  logic        grid_drive_two;
  logic        grid_drive_three;
  logic        dimming_pulse_out;
  logic        grid_sync_out_a;
  logic        grid_sync_out_b;
  wire  [2:0]  grids = {grid_drive_three, grid_drive_two, grid_drive_one};
  logic [31:0] lat [0:3];
  int          n_mismatch = 0;
  int          samples_checked = 0;
  int          k;
  int          n;
  always #2 clk = ~clk;
  vfd_dimming_grid_sequencer i_vfd_dimming_grid_sequencer (.clk, .reset, .shift_clk,
    .serial_data, .chip_select, .master_select, .duty_select, .dimming_pulse_in,
    .grid_sync_in_a, .grid_sync_in_b, .segment_outputs, .grid_drive_one, .grid_drive_two,
    .grid_drive_three, .dimming_pulse_out, .grid_sync_out_a, .grid_sync_out_b);
  serial_host_model i_serial_host_model (.shift_clk, .serial_data, .chip_select);
  // compare and report helpers
  task automatic chk_seg(input logic [31:0] e);
    samples_checked++;
    if (segment_outputs !== e)
    begin
      n_mismatch++;
      $display("mismatch segment_outputs exp %h got %h", e, segment_outputs);
    end
  endtask
  task automatic chk_grid(input logic [2:0] e);
    samples_checked++;
    if (grids !== e)
    begin
      n_mismatch++;
      $display("mismatch grids exp %b got %b", e, grids);
    end
  endtask
  task automatic chk_num(input int e, input int g);
    samples_checked++;
    if (g != e)
    begin
      n_mismatch++;
      $display("mismatch count exp %0d got %0d", e, g);
    end
  endtask
  task automatic conclude();
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic settle(input int c);
    repeat (c) @(negedge clk);
  endtask
  task automatic wr(input logic [34:0] f, input int b);
    i_serial_host_model.send(f, b);
    settle(10);
  endtask
  // next full on-phase length in clocks
  task automatic pulse_len(output int c);
    c = 0;
    for (k = 0; k < 9000 && dimming_pulse_out !== 1'b0; k++) @(negedge clk);
    for (k = 0; k < 9000 && dimming_pulse_out !== 1'b1; k++) @(negedge clk);
    for (k = 0; k < 9000 && dimming_pulse_out === 1'b1; k++)
    begin
      @(negedge clk);
      c++;
    end
  endtask
  initial
  begin
    lat[0] = 32'h0000_0000;
    lat[1] = 32'h8000_0001;
    lat[2] = 32'h1234_5678;
    lat[3] = 32'h0f0f_a5c3;
    settle(16);
    chk_seg(32'h0000_0000);
    chk_grid(3'h6);
    reset = 1'b0;
    settle(2);
    // slave: shared write, then refused code
    wr({3'h0, 32'h5555_aaaa}, 35);
    wr({3'h5, 32'h0000_ffff}, 35);
    dimming_pulse_in = 1'b1;
    grid_sync_in_a = 1'b1;
    grid_sync_in_b = 1'b1;
    settle(8);
    chk_seg(32'h5555_aaaa);
    for (n = 1; n < 4; n++) wr({n[2:0], lat[n]}, 35);
    for (n = 0; n < 4; n++)
    begin
      grid_sync_in_a = n[0];
      grid_sync_in_b = n[1];
      settle(8);
      chk_seg(lat[n]);
    end
    chk_grid(3'h7);
    dimming_pulse_in = 1'b0;
    settle(8);
    chk_seg(32'h0000_0000);
    // master: sync inputs left high, own timing
    master_select = 1'b1;
    wr({22'h00_0000, 3'h4, 10'h040}, 13);
    pulse_len(n);
    chk_num(256, n);
    for (n = 0; n < 3; n++)
    begin
      for (k = 0; k < 20000 && grids !== ~(3'h1 << n); k++) @(negedge clk);
      chk_seg(lat[n + 1]);
    end
    wr({22'h00_0000, 3'h4, 10'h3fc}, 13);
    pulse_len(n);
    chk_num(4064, n);
    wr({22'h00_0000, 3'h1, 10'h005}, 13);
    pulse_len(n);
    chk_num(4064, n);
    duty_select = 1'b1;
    settle(4200);
    n = 0;
    for (k = 0; k < 12300; k++)
    begin
      @(negedge clk);
      n += int'(grid_drive_three === 1'b0);
    end
    chk_num(0, n);
    conclude();
  end
  initial
  begin
    #300000;
    n_mismatch++;
    conclude();
  end
endmodule
bind vfd_dimming_grid_sequencer vfd_monitor i_vfd_monitor (.clk, .reset, .master_select,
  .dimming_pulse_in, .grid_sync_in_a, .grid_sync_in_b, .segment_outputs, .grid_drive_one,
  .grid_drive_two, .grid_drive_three, .dimming_pulse_out, .grid_sync_out_a, .grid_sync_out_b);
`default_nettype wire
